// [design/hmc_pkg.sv]
`default_nettype none
package hmc_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_FAN_MODE  = 8'h05;
   localparam logic [7:0] ADDR_OT_CFG    = 8'h06;
   localparam logic [7:0] ADDR_PACING    = 8'h07;
   localparam logic [7:0] RST_FAN_MODE   = 8'h14;
   localparam logic [7:0] RST_OT_CFG     = 8'h01;
   localparam logic [7:0] RST_PACING     = 8'h00;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_A_LEVEL   = 0;
   localparam int BIT_B_LEVEL   = 1;
   localparam int POS_A_DIV     = 2;
   localparam int POS_B_DIV     = 4;
   localparam int BIT_OT_EN     = 6;
   localparam int BIT_RST_EN    = 7;
   localparam int BIT_OT_STAT   = 0;
   localparam int BIT_OT_POL    = 1;
   localparam int BIT_OT_ONCE   = 2;
   localparam int BIT_HIRES     = 3;
   localparam int POS_TEMP_NIB  = 4;
   localparam int BIT_RATE_SEL  = 0;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam longint CLK_HZ        = 25000000;
   localparam longint ROUND_US      = 728000;
   localparam longint VOLT_US       = 3000;
   localparam longint TEMP_LO_US    = 3600;
   localparam longint TEMP_HI_US    = 23500;
   localparam int     VOLT_CHANNELS = 7;
   localparam int     CYC_ROUND   = int'(ROUND_US * CLK_HZ / 1000000);
   localparam int     CYC_VOLT    = int'(VOLT_US * CLK_HZ / 1000000);
   localparam int     CYC_TEMP_LO = int'(TEMP_LO_US * CLK_HZ / 1000000);
   localparam int     CYC_TEMP_HI = int'(TEMP_HI_US * CLK_HZ / 1000000);
   localparam int     CNT_W       = 25;
   localparam int     TACH_W      = 16;

   typedef enum logic [2:0] {
      HMC_IDLE  = 3'b000,
      HMC_VOLT  = 3'b001,
      HMC_TEMP  = 3'b010,
      HMC_FAN_A = 3'b011,
      HMC_FAN_B = 3'b100,
      HMC_WAIT  = 3'b101
   } hmc_seq_t;
endpackage
`default_nettype wire

// [design/hmc_tach.sv]
`default_nettype none
module hmc_tach
   import hmc_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                reset_n,
   input  wire logic                start,
   input  wire logic                tach_in,
   input  wire logic [1:0]          div_sel,
   output logic                     done,
   output logic [hmc_pkg::TACH_W-1:0] count
);
   // ---------------------------------------------------------------
   // measures two rising tach edges, counting prescaled clocks
   // ---------------------------------------------------------------
   logic [1:0]        edges, next_edges;
   logic              busy, next_busy, prev_in, next_prev_in;
   logic              next_done;
   logic [7:0]        pre, next_pre;
   logic [TACH_W-1:0] next_count;
   logic              tick;

   // prescaler period is 1, 2, 4 or 8 clocks
   always_comb begin
      tick         = (pre == ((8'h01 << div_sel) - 8'h01));
      next_pre     = tick ? 8'h00 : pre + 8'h01;
      next_prev_in = tach_in;
      next_busy    = busy;
      next_edges   = edges;
      next_count   = count;
      next_done    = 1'b0;
      if (start && !busy) begin
         next_busy  = 1'b1;
         next_edges = 2'b00;
         next_count = '0;
      end else if (busy) begin
         if (tick && count != '1)
            next_count = count + 1'b1;
         if (tach_in && !prev_in) begin
            next_edges = edges + 2'b01;
            if (edges == 2'b01) begin
               next_busy = 1'b0;
               next_done = 1'b1;
            end
         end
         if (count == '1) begin // stalled fan ends measurement
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   // state registers
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         busy    <= 1'b0;
         edges   <= 2'b00;
         count   <= '0;
         done    <= 1'b0;
         pre     <= 8'h00;
         prev_in <= 1'b0;
      end else begin
         busy    <= next_busy;
         edges   <= next_edges;
         count   <= next_count;
         done    <= next_done;
         pre     <= next_pre;
         prev_in <= next_prev_in;
      end
   end
endmodule
`default_nettype wire

// [design/hmc_regs.sv]
`default_nettype none
module hmc_regs
   import hmc_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    reset_n,
   input  wire logic [7:0]              reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_rd,
   output logic [7:0]                   reg_rdata,
   input  wire logic                    fan_input_a,
   input  wire logic                    fan_input_b,
   input  wire logic                    temp_high,
   input  wire logic                    temp_clear,
   input  wire logic [3:0]              temp_low_bits,
   input  wire logic                    reset_request,
   input  wire logic                    shared_pin_in,
   output logic                         shared_pin_out,
   output logic                         shared_pin_oe,
   output logic                         fan_a_alarm,
   output logic                         fan_b_alarm,
   output logic [hmc_pkg::TACH_W-1:0]   fan_a_count,
   output logic [hmc_pkg::TACH_W-1:0]   fan_b_count,
   output logic                         round_done,
   output logic                         temp_hires
);
   import hmc_pkg::*;

   // ---------------------------------------------------------------
   // storage and synchronisers
   // ---------------------------------------------------------------
   logic [7:0]        fan_mode, next_fan_mode;
   logic [3:0]        ot_cfg, next_ot_cfg;     // bits 3:0 less status
   logic [3:0]        temp_nib, next_temp_nib;
   logic              rate_sel, next_rate_sel;
   logic [1:0]        sa, sb, sp;
   logic              ot_active, next_ot_active;
   logic              ot_fired, next_ot_fired;
   logic [7:0]        next_rdata;
   logic              next_pin_out, next_pin_oe;
   logic              next_fa, next_fb;
   hmc_seq_t          seq, next_seq;
   logic [CNT_W-1:0]  tmr, next_tmr;
   logic [CNT_W-1:0]  round_tmr, next_round_tmr;
   logic [2:0]        chan, next_chan;
   logic              next_round_done;
   logic              start_a, start_b, done_a, done_b;

   // two-flop synchronisers for pins
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sa <= 2'b00;
         sb <= 2'b00;
         sp <= 2'b00;
      end else begin
         sa <= {sa[0], fan_input_a};
         sb <= {sb[0], fan_input_b};
         sp <= {sp[0], shared_pin_in};
      end
   end

   // level alarm with selectable active level
   function automatic logic lvl_alarm(input logic pin, input logic low);
      lvl_alarm = low ? !pin : pin;
   endfunction

   // timer load value for a span of so many clocks
   function automatic logic [CNT_W-1:0] tmr_load(input int cycles);
      tmr_load = CNT_W'(cycles - 1);
   endfunction

   // ---------------------------------------------------------------
   // register writes and reads
   // ---------------------------------------------------------------
   always_comb begin
      next_fan_mode = fan_mode;
      next_ot_cfg   = ot_cfg;
      next_rate_sel = rate_sel;
      next_temp_nib = temp_nib;
      if (temp_clear || temp_high)
         next_temp_nib = temp_low_bits;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_FAN_MODE: next_fan_mode = reg_wdata;
            ADDR_OT_CFG: begin
               next_ot_cfg   = {reg_wdata[BIT_HIRES:BIT_OT_POL], 1'b0};
               next_temp_nib = reg_wdata[7:POS_TEMP_NIB];
            end
            ADDR_PACING: next_rate_sel = reg_wdata[BIT_RATE_SEL];
            default: ;
         endcase
      end
      // read data is registered and holds between read strobes
      next_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_FAN_MODE: next_rdata = fan_mode;
            ADDR_OT_CFG: begin
               next_rdata = {temp_nib, ot_cfg[3:1], sp[1]};
               if (!ot_cfg[BIT_HIRES])
                  next_rdata[6:4] = 3'b000;
            end
            ADDR_PACING: next_rdata = {7'h00, rate_sel};
            default: next_rdata = 8'h00;
         endcase
      end else begin
         next_rdata = reg_rdata;
      end
   end

   // ---------------------------------------------------------------
   // shared pin routing and overtemp behaviour
   // ---------------------------------------------------------------
   always_comb begin
      next_ot_fired  = ot_fired;
      next_ot_active = ot_active;
      if (ot_cfg[BIT_OT_ONCE]) begin
         // one-time: assert once per excursion, read clears
         if (temp_high && !ot_fired) begin
            next_ot_active = 1'b1;
            next_ot_fired  = 1'b1;
         end else if (reg_rd && reg_addr == ADDR_OT_CFG) begin
            next_ot_active = 1'b0;
         end
         if (temp_clear)
            next_ot_fired = 1'b0;
      end else begin
         // comparator: assert on high, release on hysteresis
         if (temp_high)
            next_ot_active = 1'b1;
         else if (temp_clear)
            next_ot_active = 1'b0;
         next_ot_fired = 1'b0;
      end

      // shared pin follows fan register bits 7:6
      next_pin_out = 1'b0;
      next_pin_oe  = 1'b0;
      if (fan_mode[BIT_RST_EN]) begin
         next_pin_oe = reset_request;
      end else if (fan_mode[BIT_OT_EN]) begin
         // open-drain: drive low when asserted with low polarity, or deasserted with high polarity
         next_pin_oe = ot_active ^ ot_cfg[BIT_OT_POL];
      end
   end

   // fan level alarms
   always_comb begin
      next_fa = fan_mode[BIT_A_LEVEL] &&
                lvl_alarm(sa[1], fan_mode[POS_A_DIV]);
      next_fb = fan_mode[BIT_B_LEVEL] &&
                lvl_alarm(sb[1], fan_mode[POS_B_DIV]);
   end

   // ---------------------------------------------------------------
   // monitoring round sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_seq        = seq;
      next_tmr        = tmr;
      next_chan       = chan;
      next_round_done = 1'b0;
      start_a         = 1'b0;
      start_b         = 1'b0;
      next_round_tmr  = (round_tmr == '0) ? '0 : round_tmr - 1'b1;
      case (seq)
         HMC_IDLE: begin
            next_seq       = HMC_VOLT;
            next_chan      = 3'd0;
            next_tmr       = tmr_load(CYC_VOLT);
            next_round_tmr = tmr_load(CYC_ROUND);
         end
         HMC_VOLT: begin
            if (tmr != '0) begin
               next_tmr = tmr - 1'b1;
            end else if (chan == 3'(VOLT_CHANNELS - 1)) begin
               next_seq = HMC_TEMP;
               next_tmr = ot_cfg[BIT_HIRES] ?
                          tmr_load(CYC_TEMP_HI) :
                          tmr_load(CYC_TEMP_LO);
            end else begin
               next_chan = chan + 3'd1;
               next_tmr  = tmr_load(CYC_VOLT);
            end
         end
         HMC_TEMP: begin
            if (tmr != '0)
               next_tmr = tmr - 1'b1;
            else begin
               next_seq = HMC_FAN_A;
               start_a  = !fan_mode[BIT_A_LEVEL];
            end
         end
         HMC_FAN_A: begin
            if (fan_mode[BIT_A_LEVEL] || done_a) begin
               next_seq = HMC_FAN_B;
               start_b  = !fan_mode[BIT_B_LEVEL];
            end
         end
         HMC_FAN_B: begin
            if (fan_mode[BIT_B_LEVEL] || done_b) begin
               next_seq        = HMC_WAIT;
               next_round_done = 1'b1;
            end
         end
         HMC_WAIT: begin
            if (rate_sel || round_tmr == '0)
               next_seq = HMC_IDLE;
         end
         default: next_seq = HMC_IDLE;
      endcase
   end

   // tachometer counters with divisor prescale
   hmc_tach u_tach_a (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .start   (start_a),
      .tach_in (sa[1]),
      .div_sel (fan_mode[POS_A_DIV +: 2]),
      .done    (done_a),
      .count   (fan_a_count)
   );

   // fan_input_b is measured once fan_input_a has finished
   hmc_tach u_tach_b (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .start   (start_b),
      .tach_in (sb[1]),
      .div_sel (fan_mode[POS_B_DIV +: 2]),
      .done    (done_b),
      .count   (fan_b_count)
   );

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         fan_mode       <= RST_FAN_MODE;
         ot_cfg         <= RST_OT_CFG[3:0];
         temp_nib       <= RST_OT_CFG[7:4];
         rate_sel       <= RST_PACING[0];
         reg_rdata      <= 8'h00;
         ot_active      <= 1'b0;
         ot_fired       <= 1'b0;
         shared_pin_out <= 1'b0;
         shared_pin_oe  <= 1'b0;
         fan_a_alarm    <= 1'b0;
         fan_b_alarm    <= 1'b0;
         seq            <= HMC_IDLE;
         tmr            <= '0;
         round_tmr      <= '0;
         chan           <= 3'd0;
         round_done     <= 1'b0;
         temp_hires     <= 1'b0;
      end else begin
         fan_mode       <= next_fan_mode;
         ot_cfg         <= next_ot_cfg;
         temp_nib       <= next_temp_nib;
         rate_sel       <= next_rate_sel;
         reg_rdata      <= next_rdata;
         ot_active      <= next_ot_active;
         ot_fired       <= next_ot_fired;
         shared_pin_out <= next_pin_out;
         shared_pin_oe  <= next_pin_oe;
         fan_a_alarm    <= next_fa;
         fan_b_alarm    <= next_fb;
         seq            <= next_seq;
         tmr            <= next_tmr;
         round_tmr      <= next_round_tmr;
         chan           <= next_chan;
         round_done     <= next_round_done;
         temp_hires     <= next_ot_cfg[BIT_HIRES];
      end
   end
endmodule
`default_nettype wire

// [testbench/hmc_regs_sva.sv]
`default_nettype none
module hmc_regs_sva
   import hmc_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reset_request,
   input wire logic       shared_pin_out,
   input wire logic       shared_pin_oe,
   input wire logic       fan_a_alarm,
   input wire logic       temp_hires
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // shadow of the fields that steer the pin, the alarms and the resolution output
   // ------------------------------------------------------------
   logic [7:0] sh_fan;
   logic [7:0] next_sh_fan;
   logic       sh_hires;
   logic       next_sh_hires;

   // follow register writes seen at the ports
   always_comb begin
      next_sh_fan = sh_fan;
      next_sh_hires = sh_hires;
      if (reg_wr && reg_addr == ADDR_FAN_MODE) begin
         next_sh_fan = reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_OT_CFG) begin
         next_sh_hires = reg_wdata[BIT_HIRES];
      end
   end

   // register the shadow, loaded with reset values
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sh_fan <= RST_FAN_MODE;
         sh_hires <= 1'b0;
      end else begin
         sh_fan <= next_sh_fan;
         sh_hires <= next_sh_hires;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_reset_route: assert property (
      sh_fan[7] |=> shared_pin_oe == $past(reset_request))
      else $error("shared pin does not follow reset request");
   a_pin_disabled: assert property (
      !sh_fan[7] && !sh_fan[6] |=> !shared_pin_oe)
      else $error("shared pin driven while disabled");
   a_open_drain: assert property (
      shared_pin_out == 1'b0)
      else $error("shared pin drives a high level");
   a_pacing_zero: assert property (
      reg_rd && reg_addr == ADDR_PACING |=> reg_rdata[7:1] == 7'h00)
      else $error("pacing reserved bits not zero");
   a_fan_readback: assert property (
      reg_rd && !reg_wr && reg_addr == ADDR_FAN_MODE |=> reg_rdata == sh_fan)
      else $error("fan register readback wrong");
   a_rdata_hold: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (
      reg_rd && (reg_addr < ADDR_FAN_MODE || reg_addr > ADDR_PACING)
      |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_hires_copy: assert property (
      sh_hires == $past(sh_hires) && sh_hires == $past(sh_hires, 2)
      |-> temp_hires == sh_hires)
      else $error("resolution output differs from register");
   a_alarm_tach_mode: assert property (
      !sh_fan[0] && !$past(sh_fan[0]) && !$past(sh_fan[0], 2)
      |-> !fan_a_alarm)
      else $error("fan a alarm raised in count mode");
endmodule

bind hmc_regs hmc_regs_sva hmc_regs_sva_inst (
   .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reset_request(reset_request),
   .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
   .fan_a_alarm(fan_a_alarm), .temp_hires(temp_hires)
);
`default_nettype wire

// [testbench/hmc_host.sv]
`default_nettype none
module hmc_host (
   input  wire logic       ref_clk,
   output logic [7:0]      reg_addr,
   output logic            reg_wr,
   output logic [7:0]      reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // parallel register host front end: one-cycle strobes after each edge
   // ------------------------------------------------------------
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end

   // write strobe; idle lines show the inverse afterwards
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // read strobe; data stands from the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// [testbench/test_monitor_fan_os_rate_config.sv]
`default_nettype none
module test_monitor_fan_os_rate_config;
   timeunit 1ns;
   timeprecision 1ps;
   import hmc_pkg::*;
   // ------------------------------------------------------------
   // device, host and pin
   // ------------------------------------------------------------
   logic       ref_clk = 1'b0;
   logic       reset_n;
   logic [7:0] reg_addr;
   logic       reg_wr;
   logic [7:0] reg_wdata;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       fan_input_a;
   logic       fan_input_b;
   logic       temp_high;
   logic       temp_clear;
   logic       reset_request;
   logic       shared_pin_in;
   logic       shared_pin_oe;
   logic       fan_a_alarm;
   logic       fan_b_alarm;
   logic       temp_hires;
   logic [3:0] temp_low_bits;
   logic [15:0] fan_a_count;
   logic [15:0] fan_b_count;
   logic       round_done;
   logic       seen_round = 1'b0;
   int         err_count = 0;
   int         n_compared = 0;
   // level table: config, {fan a, fan b, alarm a, alarm b}
   logic [7:0] lv_cfg [6] = '{8'h03, 8'h03, 8'h17, 8'h17, 8'h14, 8'h00};
   logic [3:0] lv_io [6] = '{4'b1010, 4'b0101, 4'b0110, 4'b1001,
                             4'b1100, 4'b1100};
   // pin table: config, {reset request, pin enable}
   logic [7:0] pn_cfg [6] = '{8'h80, 8'h80, 8'hc0, 8'hc0, 8'h00, 8'h40};
   logic [1:0] pn_io [6] = '{2'b11, 2'b00, 2'b11, 2'b00, 2'b10, 2'b10};

   always #20 ref_clk = ~ref_clk;
   // pull-up on the open-drain shared pin
   assign shared_pin_in = !shared_pin_oe;

   // a finished round stands one cycle, so it is latched
   always @(posedge ref_clk)
      if (reset_n === 1'b1 && round_done !== 1'b0)
         seen_round <= 1'b1;

   hmc_regs hmc_regs_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fan_input_a(fan_input_a),
      .fan_input_b(fan_input_b), .temp_high(temp_high),
      .temp_clear(temp_clear), .temp_low_bits(temp_low_bits),
      .reset_request(reset_request), .shared_pin_in(shared_pin_in),
      .shared_pin_out(), .shared_pin_oe(shared_pin_oe),
      .fan_a_alarm(fan_a_alarm), .fan_b_alarm(fan_b_alarm),
      .fan_a_count(fan_a_count), .fan_b_count(fan_b_count),
      .round_done(round_done),
      .temp_hires(temp_hires)
   );

   hmc_host hmc_host_inst (
      .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      hmc_host_inst.rd(a, d);
      chk($sformatf("register %h", a), d, exp);
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      hmc_host_inst.wr(a, d);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // one-cycle pulse of the below-hysteresis event
   task automatic tclr;
      temp_high = 1'b0;
      temp_clear = 1'b1;
      cyc(1);
      temp_clear = 1'b0;
      cyc(5);
   endtask

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_count++;
      test_done();
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      fan_input_a = 1'b0;
      fan_input_b = 1'b0;
      temp_high = 1'b0;
      temp_clear = 1'b0;
      temp_low_bits = 4'h0;
      reset_request = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      rchk(ADDR_FAN_MODE, RST_FAN_MODE);
      rchk(ADDR_OT_CFG, RST_OT_CFG);
      rchk(ADDR_PACING, RST_PACING);
      for (int i = 0; i < 4; i++) begin
         wreg(ADDR_FAN_MODE, {2'b00, 2'(i), 2'(3 - i), 2'b00});
         rchk(ADDR_FAN_MODE, {2'b00, 2'(i), 2'(3 - i), 2'b00});
      end
      for (int i = 0; i < 6; i++) begin
         wreg(ADDR_FAN_MODE, lv_cfg[i]);
         fan_input_a = lv_io[i][3];
         fan_input_b = lv_io[i][2];
         cyc(6);
         chk("alarm a", 8'(fan_a_alarm), 8'(lv_io[i][1]));
         chk("alarm b", 8'(fan_b_alarm), 8'(lv_io[i][0]));
      end
      for (int i = 0; i < 6; i++) begin
         wreg(ADDR_FAN_MODE, pn_cfg[i]);
         reset_request = pn_io[i][1];
         cyc(3);
         chk("pin", 8'(shared_pin_oe), 8'(pn_io[i][0]));
      end
      reset_request = 1'b0;
      temp_high = 1'b1;
      cyc(5);
      chk("pin", 8'(shared_pin_oe), 8'h01);
      rchk(ADDR_OT_CFG, 8'h00);
      chk("pin", 8'(shared_pin_oe), 8'h01);
      tclr();
      chk("pin", 8'(shared_pin_oe), 8'h00);
      wreg(ADDR_OT_CFG, 8'h02);
      cyc(3);
      chk("pin", 8'(shared_pin_oe), 8'h01);
      temp_high = 1'b1;
      cyc(5);
      chk("pin", 8'(shared_pin_oe), 8'h00);
      rchk(ADDR_OT_CFG, 8'h03);
      tclr();
      wreg(ADDR_OT_CFG, 8'h04);
      temp_high = 1'b1;
      cyc(1);
      temp_high = 1'b0;
      cyc(5);
      chk("pin", 8'(shared_pin_oe), 8'h01);
      rchk(ADDR_OT_CFG, 8'h04);
      cyc(3);
      chk("pin", 8'(shared_pin_oe), 8'h00);
      tclr();
      wreg(ADDR_FAN_MODE, 8'h00);
      wreg(ADDR_OT_CFG, 8'hf9);
      cyc(4);
      rchk(ADDR_OT_CFG, 8'hf9);
      chk("temp_hires", 8'(temp_hires), 8'h01);
      temp_low_bits = 4'h6;
      temp_high = 1'b1;
      cyc(1);
      temp_high = 1'b0;
      cyc(1);
      rchk(ADDR_OT_CFG, 8'h69);
      tclr();
      wreg(ADDR_OT_CFG, 8'hf0);
      rchk(ADDR_OT_CFG, 8'h81);
      chk("temp_hires", 8'(temp_hires), 8'h00);
      wreg(ADDR_PACING, 8'hff);
      rchk(ADDR_PACING, 8'h01);
      wreg(ADDR_PACING, 8'h00);
      rchk(ADDR_PACING, 8'h00);
      wreg(8'h08, 8'hff);
      rchk(8'h08, 8'h00);
      rchk(8'h04, 8'h00);
      rchk(ADDR_FAN_MODE, 8'h00);
      chk("round done", 8'(seen_round), 8'h00);
      chk("fan a count", 8'(|fan_a_count), 8'h00);
      chk("fan b count", 8'(|fan_b_count), 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
